// file: sim/reset_status_and_jtag_pin_enable_bench.sv
`timescale 1ns/1ps
`include "rst_jtag_regs.svh"
module reset_status_and_jtag_pin_enable_bench;
  logic clk, rst_n, resetPinN, supplyLockout, powerDown, memAccessEn, resetActive, logicOutValid;
  logic codeSpaceSelect, peripheralMode, flashProgReq, flashEraseReq, flashOpDone, flashOpFail, flashBusy;
  logic addrOutEn, dataPortEn, periphIoEn, nvmScanDedicate, blankDevice, scanSelectTerm, scanPinsActive;
  logic scanClk, tms, tdi, cableEnableN, tdoOut, tdoOe, statusOut, statusOe, errorOut, errorOe;
  logic [7:0] busRdata, mcellD, mcellResetEq, mcellPresetEq, mcellQ, mcuIoDir, portOut, portOe;
  logic [7:0] pcIn, pcOut, pcOe, portInSync, pcRnd;
  rst_jtag_pkg::reg_req_s    regReq;
  rst_jtag_pkg::ctrl_lines_s ctrlPins, arrayCtrl;
  int fails, n_checks, seed, n;
  int regM [int];
  logic [7:0] cmds [4] = '{8'h0f, `CMD_DISABLE, `CMD_ENABLE, `CMD_ENABLE_EXT};
  logic [2:0] oes [4] = '{3'b111, 3'b000, 3'b100, 3'b111};

  // Pin levels seen by the port, data out resolved from both drivers
  assign pcIn = {pcRnd[7], tdoOe ? tdoOut : (pcOe[6] ? pcOut[6] : pcRnd[6]), tdi, pcRnd[4:2], scanClk, tms};
  assign scanSelectTerm = ~cableEnableN;

  reset_status_and_jtag_pin_enable i_reset_status_and_jtag_pin_enable (.*);
  scan_host_model i_scan_host_model (.scanClk(scanClk), .tms(tms), .tdi(tdi), .cableEnableN(cableEnableN));

  // System clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (fails == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Bounded wait; running out ends the run
  task automatic waitFor(ref logic s, input logic v, input int lim, output int t);
    t = 0;
    while (s !== v) begin
      step(1);
      t++;
      if (t > lim) begin
        fails++;
        wrap_up();
      end
    end
  endtask
  // Gate register survives pin reset, the others do not
  task automatic clearRegs(input bit por);
    regM[`SCAN_EN_OFFSET] = 0;
    regM[`MEM_MAP_OFFSET] = 0;
    regM[`IO_DIR_OFFSET] = 0;
    if (por) regM[`GATE_CTRL_OFFSET] = 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regReq = '{1'b1, 1'b1, 1'b0, a, d};
    step(1);
    regReq = '0;
    step(1);
    if (regM.exists(a)) regM[a] = d;
  endtask
  task automatic rd(input logic [7:0] a);
    regReq = '{1'b1, 1'b0, 1'b1, a, 8'h00};
    step(1);
    regReq = '0;
    step(1);
    chk(busRdata, regM.exists(a) ? 8'(regM[a]) : 8'h00);
  endtask
  task automatic readAll();
    foreach (regM[a]) rd(8'(a));
    rd(8'h10);
  endtask

  initial begin
    seed = 72912;
    fails = 0;
    n_checks = 0;
    {rst_n, resetPinN, supplyLockout, powerDown, nvmScanDedicate, blankDevice} = 6'b010000;
    {flashProgReq, flashEraseReq, flashOpDone, flashOpFail} = 4'h0;
    {regReq, ctrlPins, mcellD, mcellResetEq, mcellPresetEq, portOut, portOe, pcRnd} = '0;
    clearRegs(1'b1);
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    waitFor(memAccessEn, 1'b1, 100, n);
    chk(8'(n >= `CFG_LOAD_CYCLES - 1), 8'h01);
    chk({6'h00, logicOutValid, flashBusy}, 8'h02);
    chk(mcellQ, 8'h00);
    wr(8'h10, 8'hff);
    readAll();
    // Random register contents, gating and macrocell equations
    for (int i = 0; i < 6; i++) begin
      wr(`GATE_CTRL_OFFSET, 8'($random(seed)) & 8'h7c);
      wr(`MEM_MAP_OFFSET, 8'($random(seed)) & 8'h03);
      wr(`IO_DIR_OFFSET, 8'($random(seed)));
      ctrlPins = 5'($random(seed));
      pcRnd = 8'($random(seed));
      {mcellD, mcellResetEq, mcellPresetEq} = 24'($random(seed));
      step(4);
      chk(8'(arrayCtrl), 8'(ctrlPins & ~5'(regM[`GATE_CTRL_OFFSET] >> 2)));
      chk({6'h00, peripheralMode, codeSpaceSelect}, 8'(regM[`MEM_MAP_OFFSET]));
      chk(mcuIoDir, 8'(regM[`IO_DIR_OFFSET]));
      chk(mcellQ, (mcellD | mcellPresetEq) & ~mcellResetEq);
      chk(portInSync, pcIn);
      readAll();
    end
    // Register-enabled scan, an undefined code and the enable, extended-enable and disable codes
    wr(`SCAN_EN_OFFSET, 8'h01);
    step(3);
    chk({6'h00, scanPinsActive, tdoOe}, 8'h02);
    i_scan_host_model.send(`CMD_ENABLE_EXT);
    for (int i = 0; i < 4; i++) begin
      i_scan_host_model.send(cmds[i]);
      step(5);
      chk({5'h00, tdoOe, statusOe, errorOe}, {5'h00, oes[i]});
    end
    // Lockout, then a failing cycle and its clear
    supplyLockout = 1'b1;
    step(3);
    flashProgReq = 1'b1;
    step(10);
    chk(8'(flashBusy), 8'h00);
    supplyLockout = 1'b0;
    waitFor(flashBusy, 1'b1, 10, n);
    flashProgReq = 1'b0;
    flashOpFail = 1'b1;
    step(1);
    flashOpFail = 1'b0;
    step(20);
    chk({5'h00, statusOut, flashBusy, errorOut}, 8'h04);
    i_scan_host_model.send(`CMD_CLEAR);
    step(5);
    chk(8'(errorOut), 8'h01);
    flashProgReq = 1'b1;
    waitFor(flashBusy, 1'b1, 10, n);
    {flashProgReq, flashOpDone} = 2'b01;
    step(1);
    flashOpDone = 1'b0;
    step(3);
    chk({6'h00, flashBusy, errorOut}, 8'h01);
    // Warm reset in mid-erase
    flashEraseReq = 1'b1;
    waitFor(flashBusy, 1'b1, 10, n);
    flashEraseReq = 1'b0;
    resetPinN = 1'b0;
    step(6);
    clearRegs(1'b0);
    chk({3'h0, resetActive, addrOutEn, scanPinsActive, tdoOe, logicOutValid}, 8'h11);
    resetPinN = 1'b1;
    waitFor(memAccessEn, 1'b1, 60, n);
    chk(8'(n >= `POST_RESET_CYCLES), 8'h01);
    readAll();
    waitFor(flashBusy, 1'b0, `CYCLE_ABORT_CYCLES + 20, n);
    // Normal port control, then the product term
    for (int i = 0; i < 3; i++) begin
      {portOut, portOe} = 16'($random(seed));
      wr(`IO_DIR_OFFSET, 8'($random(seed)));
      step(3);
      chk(pcOut, portOut);
      chk(pcOe, portOe & 8'(regM[`IO_DIR_OFFSET]));
    end
    i_scan_host_model.cable(1'b1);
    step(3);
    chk(8'(scanPinsActive), 8'h01);
    i_scan_host_model.cable(1'b0);
    step(3);
    chk(8'(scanPinsActive), 8'h00);
    // Dedicated and blank sources ride through a reset
    for (int s = 0; s < 2; s++) begin
      {blankDevice, nvmScanDedicate} = 2'(s + 1);
      step(4);
      resetPinN = 1'b0;
      i_scan_host_model.send(`CMD_ENABLE);
      step(3);
      chk({6'h00, scanPinsActive, tdoOe}, 8'h03);
      resetPinN = 1'b1;
      i_scan_host_model.send(`CMD_DISABLE);
      step(1);
      {blankDevice, nvmScanDedicate} = 2'b00;
      waitFor(memAccessEn, 1'b1, 60, n);
    end
    // Power-down keeps direction, data side undriven
    wr(`IO_DIR_OFFSET, 8'h5a);
    powerDown = 1'b1;
    step(4);
    chk(mcuIoDir, 8'h5a);
    chk({6'h00, dataPortEn, periphIoEn}, 8'h00);
    wrap_up();
  end
endmodule

// file: sim/rst_seq_checker.sv
`timescale 1ns/1ps
`include "rst_jtag_regs.svh"
module rst_seq_checker (
  // Clock and resets
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       resetPinN,
  // Watched status
  input wire logic       supplyLockout,
  input wire logic       flashBusy,
  input wire logic       memAccessEn,
  input wire logic       resetActive,
  input wire logic       logicOutValid,
  input wire logic       codeSpaceSelect,
  input wire logic       peripheralMode,
  input wire logic       addrOutEn,
  input wire logic       dataPortEn,
  input wire logic       periphIoEn,
  input wire logic       scanPinsActive,
  input wire logic       tdoOe,
  input wire logic [7:0] mcuIoDir,
  input wire logic [7:0] pcOe
);
  localparam int AbortLimit = `CYCLE_ABORT_CYCLES + 16;
  logic abortArm;
  int   abortCnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Busy time once a reset hits a running cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      abortArm <= 1'b0;
      abortCnt <= 0;
    end else begin
      abortArm <= flashBusy && (abortArm || !resetPinN);
      abortCnt <= abortArm ? abortCnt + 1 : 0;
    end
  end
  a_wait_no_access: assert property (resetActive |-> !memAccessEn)
    else $error("memory access open in reset");
  a_pin_blocks_mem: assert property (!resetPinN [*5] |-> !memAccessEn && resetActive)
    else $error("pin reset did not block access");
  a_lockout_blocks: assert property (supplyLockout [*8] |=> !$rose(flashBusy))
    else $error("flash cycle started under lockout");
  a_access_gates: assert property (!memAccessEn [*4] |=> !$rose(flashBusy))
    else $error("flash cycle started without access");
  a_abort_bound: assert property (abortCnt <= AbortLimit)
    else $error("aborted cycle too long");
  a_scan_starts_in: assert property ($rose(scanPinsActive) |-> !tdoOe)
    else $error("data out driven at scan start");
  a_scan_pins_in: assert property (scanPinsActive && $past(scanPinsActive) |-> pcOe[1:0] == 2'b00 && !pcOe[5])
    else $error("scan input pin driven");
  a_reset_tristate: assert property (!resetPinN [*5] |-> !addrOutEn && !dataPortEn && !periphIoEn)
    else $error("port driven in reset");
  a_reset_dir_in: assert property (!resetPinN [*5] |-> mcuIoDir == 8'h00)
    else $error("port not input in reset");
  a_map_cleared: assert property (!resetPinN [*5] |-> !codeSpaceSelect && !peripheralMode)
    else $error("map bits kept in reset");
  a_valid_kept: assert property (logicOutValid |=> logicOutValid)
    else $error("array outputs lost validity");
  // Main scenarios reached
  c_flash: cover property ($rose(flashBusy));
  c_tdo: cover property ($rose(tdoOe));
  c_wait_done: cover property ($fell(resetActive));
  c_scan: cover property ($rose(scanPinsActive));
endmodule

bind reset_status_and_jtag_pin_enable rst_seq_checker i_rst_seq_checker (
  .clk(clk), .rst_n(rst_n), .resetPinN(resetPinN), .supplyLockout(supplyLockout), .flashBusy(flashBusy),
  .memAccessEn(memAccessEn), .resetActive(resetActive), .logicOutValid(logicOutValid),
  .codeSpaceSelect(codeSpaceSelect), .peripheralMode(peripheralMode), .addrOutEn(addrOutEn),
  .dataPortEn(dataPortEn), .periphIoEn(periphIoEn), .scanPinsActive(scanPinsActive), .tdoOe(tdoOe),
  .mcuIoDir(mcuIoDir), .pcOe(pcOe)
);

// file: sim/scan_host_model.sv
`timescale 1ns/1ps
module scan_host_model (
  // Link lines toward the port pins
  output logic scanClk,
  output logic tms,
  output logic tdi,
  output logic cableEnableN
);
  // Link clock stands low outside frames
  initial begin
    {scanClk, tms, tdi, cableEnableN} = 4'b0101;
  end
  // One link cycle; data shows its inverse once released
  task automatic tick(input logic m, input logic d);
    tms = m;
    tdi = d;
    #62.5 scanClk = 1'b1;
    #62.5 scanClk = 1'b0;
    tdi = ~d;
  endtask
  // Two idle edges let the enable cross, then shift eight bits low first and execute
  task automatic send(input logic [7:0] code);
    #3.7 tick(1'b1, 1'b0);
    tick(1'b1, 1'b0);
    tick(1'b0, 1'b0);
    for (int i = 0; i < 8; i++) tick(1'b0, code[i]);
    tick(1'b1, 1'b0);
  endtask
  // Cable enable is active low
  task automatic cable(input logic on);
    cableEnableN = ~on;
  endtask
endmodule

// file: verilog/reset_status_and_jtag_pin_enable.sv
`timescale 1ns/1ps
`include "rst_jtag_regs.svh"
// Operation
// - Gate bits 2..6 set to 1 force the matching array control input inactive.
// - Reset held after power-up loads configuration, clears registers, flash operating.
// - After reset release, stay in reset and refuse memory access for post-wait.
// - Flash state machine starts in read state at power-up.
// - No flash write cycle starts while supply lockout is asserted.
// - Short warm reset accepted, followed by the same post-reset wait.
// - Array outputs valid during warm reset; after config load at power-on.
// - Reset aborts program or erase, flash back to read within abort time.
// - MCU I/O ports revert to input on resets, unchanged in power-down.
// - Address, data, peripheral ports tri-state in reset; data, peripheral in power-down.
// - Macrocell flops cleared by power-on reset; otherwise own reset/preset equations.
// - Code-space and peripheral-mode bits cleared on power-on and warm reset.
// - Scan pins assigned to test port when any of three enables is true.
// - Scan pins start as inputs; data-out drives only after enable command.
// - With no enable true, scan pins behave as normal port I/O.
// - Nonvolatile bit dedicates the pins to scan port permanently.
// - Writable enable bit at offset c7 enables pins; reset or write clears.
// - Dedicated product term enables scan pins for multiplexed use.
// - Reset leaves nonvolatile-enabled scan alone; aborts register-enabled scan.
// - Blank device enables the four basic scan pins by default.
// - Enable command may also enable status and error output pins.
// - Only configuration commands decoded; no boundary-scan instructions.
// - Bit 0 of scan enable register is the enable; other bits unused.
// - Error output goes low on program/erase failure, stays until clear, or until a reset while no enable command is in force.
module reset_status_and_jtag_pin_enable (
  // System clock and power-on reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // Reset pin and supply state
  input  wire logic                       resetPinN,
  input  wire logic                       supplyLockout,
  input  wire logic                       powerDown,
  // Register port
  input  wire rst_jtag_pkg::reg_req_s     regReq,
  output logic [7:0]                      busRdata,
  // Control inputs to the logic array
  input  wire rst_jtag_pkg::ctrl_lines_s  ctrlPins,
  output rst_jtag_pkg::ctrl_lines_s       arrayCtrl,
  // Macrocells
  input  wire logic [7:0]                 mcellD,
  input  wire logic [7:0]                 mcellResetEq,
  input  wire logic [7:0]                 mcellPresetEq,
  output logic [7:0]                      mcellQ,
  // Reset status
  output logic                            memAccessEn,
  output logic                            resetActive,
  output logic                            logicOutValid,
  output logic                            codeSpaceSelect,
  output logic                            peripheralMode,
  // Flash control
  input  wire logic                       flashProgReq,
  input  wire logic                       flashEraseReq,
  input  wire logic                       flashOpDone,
  input  wire logic                       flashOpFail,
  output logic                            flashBusy,
  // Port drive enables
  output logic [7:0]                      mcuIoDir,
  output logic                            addrOutEn,
  output logic                            dataPortEn,
  output logic                            periphIoEn,
  // Scan enable sources
  input  wire logic                       nvmScanDedicate,
  input  wire logic                       blankDevice,
  input  wire logic                       scanSelectTerm,
  // Port pins
  input  wire logic [7:0]                 pcIn,
  input  wire logic [7:0]                 portOut,
  input  wire logic [7:0]                 portOe,
  output logic [7:0]                      pcOut,
  output logic [7:0]                      pcOe,
  output logic [7:0]                      portInSync,
  output logic                            scanPinsActive,
  // Scan link
  input  wire logic                       scanClk,
  output logic                            tdoOut,
  output logic                            tdoOe,
  output logic                            statusOut,
  output logic                            statusOe,
  output logic                            errorOut,
  output logic                            errorOe
);

  // Pin synchronisers: stage one only feeds stage two
  logic [1:0] rstPinSync;
  logic [1:0] lockSync;
  logic [1:0] nvmSync;
  logic [1:0] blankSync;
  logic [4:0] ctrlSync1;
  logic [4:0] ctrlSync2;
  logic [7:0] pcSync1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPinSync <= 2'h0;
      lockSync   <= 2'h0;
      nvmSync    <= 2'h0;
      blankSync  <= 2'h0;
      ctrlSync1  <= 5'h00;
      ctrlSync2  <= 5'h00;
      pcSync1    <= 8'h00;
      portInSync <= 8'h00;
    end else begin
      rstPinSync <= {rstPinSync[0], resetPinN};
      lockSync   <= {lockSync[0], supplyLockout};
      nvmSync    <= {nvmSync[0], nvmScanDedicate};
      blankSync  <= {blankSync[0], blankDevice};
      ctrlSync1  <= ctrlPins;
      ctrlSync2  <= ctrlSync1;
      pcSync1    <= pcIn;
      portInSync <= pcSync1;
    end
  end

  // Reset decode
  wire inReset  = ~rstPinSync[1];
  wire lockout  = lockSync[1];
  wire nvmDed   = nvmSync[1] | blankSync[1];

  // Register decode
  wire regWr    = regReq.ioSel & regReq.wr & ~inReset;
  wire wrScan   = regWr & (regReq.addr == `SCAN_EN_OFFSET);
  wire wrGate   = regWr & (regReq.addr == `GATE_CTRL_OFFSET);
  wire wrMap    = regWr & (regReq.addr == `MEM_MAP_OFFSET);
  wire wrDir    = regWr & (regReq.addr == `IO_DIR_OFFSET);

  logic       scanEnReg;
  logic [7:0] gateReg;
  logic [1:0] mapReg;
  logic [7:0] dirReg;

  // Gate bits survive warm reset; only power-on clears them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gateReg <= `REG_RESET_VAL;
    end else if (wrGate) begin
      gateReg <= regReq.wdata;
    end
  end

  // Software-owned bits cleared by either reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scanEnReg <= 1'b0;
      mapReg    <= 2'h0;
      dirReg    <= `REG_RESET_VAL;
    end else if (inReset) begin
      scanEnReg <= 1'b0;
      mapReg    <= 2'h0;
      dirReg    <= `REG_RESET_VAL;
    end else begin
      if (wrScan) scanEnReg <= regReq.wdata[`SCAN_EN_BIT];
      if (wrMap) mapReg <= regReq.wdata[1:0];
      if (wrDir) dirReg <= regReq.wdata;
    end
  end

  // Read mux; unmapped offsets read zero
  wire [7:0] rdMux =
    (regReq.addr == `SCAN_EN_OFFSET)   ? {7'h00, scanEnReg} :
    (regReq.addr == `GATE_CTRL_OFFSET) ? gateReg :
    (regReq.addr == `MEM_MAP_OFFSET)   ? {6'h00, mapReg} :
    (regReq.addr == `IO_DIR_OFFSET)    ? dirReg : 8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busRdata <= 8'h00;
    end else if (regReq.ioSel & regReq.rd) begin
      busRdata <= rdMux;
    end
  end

  // Per-line gating of array control inputs
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : gGate
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          arrayCtrl[g] <= 1'b0;
        end else begin
          arrayCtrl[g] <= ctrlSync2[g] & ~gateReg[`GATE_FIRST_BIT + g];
        end
      end
    end
  endgenerate

  // Configuration load and post-reset wait
  logic [4:0] cfgCnt;
  logic [7:0] waitCnt;
  wire        cfgLoaded = (cfgCnt == 5'(`CFG_LOAD_CYCLES));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgCnt  <= 5'h00;
      waitCnt <= 8'(`POST_RESET_CYCLES);
    end else begin
      if (!cfgLoaded) cfgCnt <= cfgCnt + 5'h01;
      if (inReset) begin
        waitCnt <= 8'(`POST_RESET_CYCLES);
      end else if (waitCnt != 8'h00) begin
        waitCnt <= waitCnt - 8'h01;
      end
    end
  end

  // Status flops; array outputs stay valid once loaded, warm reset or not
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      memAccessEn   <= 1'b0;
      resetActive   <= 1'b1;
      logicOutValid <= 1'b0;
    end else begin
      memAccessEn   <= ~inReset & (waitCnt == 8'h00) & cfgLoaded;
      resetActive   <= inReset | (waitCnt != 8'h00);
      logicOutValid <= cfgLoaded;
    end
  end

  assign codeSpaceSelect = mapReg[`CODE_SPACE_BIT];
  assign peripheralMode  = mapReg[`PERIPH_MODE_BIT];
  assign mcuIoDir        = dirReg;

  // Macrocells: only power-on clears them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mcellQ <= 8'h00;
    end else begin
      mcellQ <= ~mcellResetEq & (mcellPresetEq | mcellD);
    end
  end

  // Flash control state machine
  rst_jtag_pkg::flash_state_e flState;
  logic [11:0]                abortCnt;
  wire startOk = memAccessEn & ~lockout;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flState  <= rst_jtag_pkg::FL_READ;
      abortCnt <= 12'h000;
    end else begin
      unique case (flState)
        rst_jtag_pkg::FL_READ: begin
          if (startOk & flashProgReq) flState <= rst_jtag_pkg::FL_PROGRAM;
          else if (startOk & flashEraseReq) flState <= rst_jtag_pkg::FL_ERASE;
        end
        rst_jtag_pkg::FL_PROGRAM, rst_jtag_pkg::FL_ERASE: begin
          if (inReset) begin
            flState  <= rst_jtag_pkg::FL_ABORT;
            abortCnt <= 12'(`CYCLE_ABORT_CYCLES - 1);
          end else if (flashOpDone | flashOpFail) begin
            flState <= rst_jtag_pkg::FL_READ;
          end
        end
        rst_jtag_pkg::FL_ABORT: begin
          if (abortCnt == 12'h000) flState <= rst_jtag_pkg::FL_READ;
          else abortCnt <= abortCnt - 12'h001;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flashBusy <= 1'b0;
    end else begin
      flashBusy <= (flState != rst_jtag_pkg::FL_READ);
    end
  end

  // Scan link side: commands shifted on the scan clock
  logic [1:0] scanOnTck;
  logic [1:0] abortTck;
  rst_jtag_pkg::scan_state_e scState;
  logic [7:0] shiftReg;
  logic [2:0] tmsHigh;
  logic       iscEnTck;
  logic       extEnTck;
  logic       clrTgl;
  logic       enTgl;
  wire        scanOnClk;
  wire        scanAbort;
  wire        tms = pcIn[`PIN_MODE_SEL];
  wire        tdi = pcIn[`PIN_DATA_IN];
  wire        tckReset = ~scanOnTck[1] | abortTck[1] |
                         (tmsHigh == 3'(`CMD_RESET_TMS_EDGES));

  // Level crossings into the scan clock domain
  always_ff @(posedge scanClk or negedge rst_n) begin
    if (!rst_n) begin
      scanOnTck <= 2'h0;
      abortTck  <= 2'h0;
    end else begin
      scanOnTck <= {scanOnTck[0], scanOnClk};
      abortTck  <= {abortTck[0], scanAbort};
    end
  end

  // Only configuration commands decode; anything else is ignored
  always_ff @(posedge scanClk or negedge rst_n) begin
    if (!rst_n) begin
      scState  <= rst_jtag_pkg::SC_IDLE;
      shiftReg <= 8'h00;
      tmsHigh  <= 3'h0;
      iscEnTck <= 1'b0;
      extEnTck <= 1'b0;
      clrTgl   <= 1'b0;
      enTgl    <= 1'b0;
    end else if (tckReset) begin
      scState  <= rst_jtag_pkg::SC_IDLE;
      tmsHigh  <= 3'h0;
      iscEnTck <= 1'b0;
      extEnTck <= 1'b0;
    end else begin
      tmsHigh <= tms ? tmsHigh + 3'h1 : 3'h0;
      unique case (scState)
        rst_jtag_pkg::SC_IDLE: begin
          if (!tms) scState <= rst_jtag_pkg::SC_SHIFT;
        end
        rst_jtag_pkg::SC_SHIFT: begin
          if (tms) begin
            scState <= rst_jtag_pkg::SC_IDLE;
            unique case (shiftReg)
              `CMD_ENABLE: begin
                iscEnTck <= 1'b1;
                enTgl    <= ~enTgl;
              end
              `CMD_ENABLE_EXT: begin
                iscEnTck <= 1'b1;
                enTgl    <= ~enTgl;
                extEnTck <= 1'b1;
              end
              `CMD_DISABLE: begin
                iscEnTck <= 1'b0;
                extEnTck <= 1'b0;
              end
              `CMD_CLEAR: clrTgl <= ~clrTgl;
              default: ;
            endcase
          end else begin
            shiftReg <= {tdi, shiftReg[7:1]};
          end
        end
      endcase
    end
  end

  // Serial data out, shifted low bit first
  always_ff @(posedge scanClk or negedge rst_n) begin
    if (!rst_n) begin
      tdoOut <= 1'b0;
    end else begin
      tdoOut <= shiftReg[0];
    end
  end

  // Crossings back to the system clock
  logic [1:0] iscEnSync;
  logic [1:0] extEnSync;
  logic [2:0] clrSync;
  logic [2:0] enSync;
  logic       iscArm;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      iscEnSync <= 2'h0;
      extEnSync <= 2'h0;
      clrSync   <= 3'h0;
      enSync    <= 3'h0;
    end else begin
      iscEnSync <= {iscEnSync[0], iscEnTck};
      extEnSync <= {extEnSync[0], extEnTck};
      clrSync   <= {clrSync[1:0], clrTgl};
      enSync    <= {enSync[1:0], enTgl};
    end
  end

  // Enable OR; only a reset with no dedicating source aborts scan
  assign scanOnClk = nvmDed | scanEnReg | scanSelectTerm;
  assign scanAbort = inReset & ~nvmDed;
  wire scanLive    = scanOnClk & ~scanAbort;
  wire iscLive     = scanLive & iscArm & iscEnSync[1];
  wire extLive     = iscLive & extEnSync[1];
  wire clrPulse    = clrSync[2] ^ clrSync[1];
  wire enPulse     = enSync[2] ^ enSync[1];

  // Data out arms only on a fresh enable command; an idle link clock leaves stale enables behind
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      iscArm <= 1'b0;
    end else begin
      iscArm <= scanLive & (enPulse | (iscArm & iscEnSync[1]));
    end
  end

  // Error flag: failure wins over a clear in the same cycle
  logic errFlag;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      errFlag <= 1'b0;
    end else if (flashOpFail) begin
      errFlag <= 1'b1;
    end else if (clrPulse | (inReset & ~iscEnSync[1])) begin
      errFlag <= 1'b0;
    end
  end

  // Scan pin masks and port drive enables
  wire [7:0] scanMask = scanLive ? 8'h63 : 8'h00;
  wire [7:0] extMask  = extLive ? 8'h18 : 8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pcOut          <= 8'h00;
      pcOe           <= 8'h00;
      scanPinsActive <= 1'b0;
      tdoOe          <= 1'b0;
      statusOut      <= 1'b1;
      statusOe       <= 1'b0;
      errorOut       <= 1'b1;
      errorOe        <= 1'b0;
      addrOutEn      <= 1'b0;
      dataPortEn     <= 1'b0;
      periphIoEn     <= 1'b0;
    end else begin
      pcOut          <= portOut;
      pcOe           <= portOe & dirReg & ~scanMask & ~extMask & {8{~inReset}};
      scanPinsActive <= scanLive;
      tdoOe          <= iscLive;
      statusOut      <= ~flashBusy;
      statusOe       <= extLive;
      errorOut       <= ~errFlag;
      errorOe        <= extLive;
      addrOutEn      <= ~inReset;
      dataPortEn     <= ~inReset & ~powerDown;
      periphIoEn     <= ~inReset & ~powerDown;
    end
  end

endmodule

// file: verilog/rst_jtag_pkg.sv
package rst_jtag_pkg;

  // Flash control state machine
  typedef enum logic [1:0] {
    FL_READ,
    FL_PROGRAM,
    FL_ERASE,
    FL_ABORT
  } flash_state_e;

  // Serial command shifter
  typedef enum logic [0:0] {
    SC_IDLE,
    SC_SHIFT
  } scan_state_e;

  // Microcontroller control inputs toward the logic array
  typedef struct packed {
    logic byteEnableIn;
    logic addrLatchStrobe;
    logic ctrlLineC;
    logic ctrlLineB;
    logic ctrlLineA;
  } ctrl_lines_s;

  // Register port request
  typedef struct packed {
    logic       ioSel;
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

endpackage

// file: verilog/rst_jtag_regs.svh
`ifndef RST_JTAG_REGS_SVH
`define RST_JTAG_REGS_SVH

// Register offsets inside the I/O page
`define SCAN_EN_OFFSET      8'hc7
`define GATE_CTRL_OFFSET    8'hf4
`define MEM_MAP_OFFSET      8'hf5
`define IO_DIR_OFFSET       8'hf6

// Field positions and reset values
`define SCAN_EN_BIT         0
`define GATE_FIRST_BIT      2
`define CODE_SPACE_BIT      0
`define PERIPH_MODE_BIT     1
`define REG_RESET_VAL       8'h00

// Scan-port pin positions on the port
`define PIN_MODE_SEL        0
`define PIN_SCAN_CLK        1
`define PIN_STATUS          3
`define PIN_ERROR           4
`define PIN_DATA_IN         5
`define PIN_DATA_OUT        6

// Serial command codes (values arbitrary)
`define CMD_ENABLE          8'he8
`define CMD_ENABLE_EXT      8'he9
`define CMD_DISABLE         8'hc0
`define CMD_CLEAR           8'hc3
`define CMD_RESET_TMS_EDGES 5

// Timing
`define CLK_MHZ             100
`define POST_RESET_WAIT_NS  150
`define CYCLE_ABORT_NS      25000
`define CFG_LOAD_CYCLES     16
`define POST_RESET_CYCLES   ((`POST_RESET_WAIT_NS * `CLK_MHZ + 999) / 1000)
`define CYCLE_ABORT_CYCLES  ((`CYCLE_ABORT_NS * `CLK_MHZ) / 1000)

`endif
